// File: core/tfp_gen.sv
// line-synchronous thyristor gate pattern generator with register port
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module tfp_gen #(
    parameter int CNT_W        = 22,
    parameter int SOFT_SUB_CYC = tfp_pkg::TFP_SOFT_SUB_CYC
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire tfp_pkg::tfp_bus_t bus,
    output logic [15:0]            rdata,
    input  wire tfp_pkg::tfp_line_t line,
    input  wire logic              run_enable,
    output logic                   gate
);

    localparam int SUB_W = $clog2(SOFT_SUB_CYC + 1);
    localparam int PRD_W = CNT_W + 8;

    typedef struct packed {
        tfp_pkg::tfp_cfg_t cfg;
        logic [15:0]       rdata;
        logic [CNT_W-1:0]  hc_count;
        logic [CNT_W-1:0]  period;
        logic [SUB_W-1:0]  sub_cnt;
        logic [15:0]       step_cnt;
        logic [6:0]        eff;
        logic [8:0]        acc;
        logic [7:0]        blk_cnt;
        logic [7:0]        burst_half;
        logic [7:0]        num;
        logic [7:0]        den;
        logic              burst_on;
        logic              last_pol;
        logic              half_fire;
        logic              gate;
    } tfp_state_t;

    localparam tfp_state_t TFP_STATE_RST = '{
        cfg:     tfp_pkg::TFP_CFG_RST,
        default: '0
    };

    tfp_state_t      s;
    tfp_state_t      next_s;
    logic [6:0]      target;
    logic            soft_act;
    logic            tick;
    logic            cyc;
    logic            start;
    logic [8:0]      sum;
    logic [PRD_W-1:0] lhs;
    logic [PRD_W-1:0] rhs;

    always_comb
    begin
        next_s = s;
        next_s.rdata = '0;
        sum = '0;
        cyc = line.zc && line.line_pos;
        start = 1'b0;

        if (bus.wr)
        begin
            unique case (bus.addr)
                tfp_pkg::TFP_REG_CTRL:
                begin
                    if (bus.wdata[2:0] <= tfp_pkg::TFP_MODE_MAX)
                        next_s.cfg.mode =
                            tfp_pkg::tfp_mode_t'(bus.wdata[2:0]);
                    next_s.cfg.soft_en =
                        bus.wdata[tfp_pkg::TFP_CTRL_SOFT_BIT];
                end
                tfp_pkg::TFP_REG_SETPOINT:
                    next_s.cfg.set_point =
                        (bus.wdata[6:0] > tfp_pkg::TFP_PCT_FULL) ?
                        tfp_pkg::TFP_PCT_FULL : bus.wdata[6:0];
                tfp_pkg::TFP_REG_MIN_CYC:
                    next_s.cfg.min_cycles = bus.wdata[7:0];
                tfp_pkg::TFP_REG_DELAY:
                    next_s.cfg.delay_angle = bus.wdata[7:0];
                tfp_pkg::TFP_REG_DELAY_HC:
                    next_s.cfg.delayed_half_cycle_count = bus.wdata[7:0];
                tfp_pkg::TFP_REG_SOFT_TIME:
                    next_s.cfg.soft_time = bus.wdata;
                tfp_pkg::TFP_REG_RAMP:
                    next_s.cfg.ramp_half_cycles = bus.wdata[7:0];
                default: ;
            endcase
        end

        if (bus.rd)
        begin
            unique case (bus.addr)
                tfp_pkg::TFP_REG_CTRL:
                    next_s.rdata = {12'h000, s.cfg.soft_en, s.cfg.mode};
                tfp_pkg::TFP_REG_SETPOINT:
                    next_s.rdata = {9'h000, s.cfg.set_point};
                tfp_pkg::TFP_REG_MIN_CYC:
                    next_s.rdata = {8'h00, s.cfg.min_cycles};
                tfp_pkg::TFP_REG_DELAY:
                    next_s.rdata = {8'h00, s.cfg.delay_angle};
                tfp_pkg::TFP_REG_DELAY_HC:
                    next_s.rdata = {8'h00, s.cfg.delayed_half_cycle_count};
                tfp_pkg::TFP_REG_SOFT_TIME:
                    next_s.rdata = s.cfg.soft_time;
                tfp_pkg::TFP_REG_RAMP:
                    next_s.rdata = {8'h00, s.cfg.ramp_half_cycles};
                tfp_pkg::TFP_REG_STATUS:
                    next_s.rdata = {7'h00, s.burst_on, s.gate, s.eff};
                default:
                    next_s.rdata = '0;
            endcase
        end

        // set-point filter; a 1% step every soft_time half-milliseconds
        target = run_enable ? s.cfg.set_point : 7'h00;
        soft_act = (s.cfg.mode == tfp_pkg::TFP_PHASE_SOFT) ||
                   (s.cfg.soft_en && s.cfg.mode != tfp_pkg::TFP_PHASE);
        tick = (s.sub_cnt == SUB_W'(SOFT_SUB_CYC - 1));
        next_s.sub_cnt = tick ? '0 : s.sub_cnt + 1'b1;
        if (!run_enable)
        begin
            next_s.eff = 7'h00;
            next_s.step_cnt = '0;
        end
        else if (!soft_act || s.cfg.soft_time == 16'h0000)
            next_s.eff = target;
        else if (tick)
        begin
            if (s.step_cnt + 16'h0001 >= s.cfg.soft_time)
            begin
                next_s.step_cnt = '0;
                // rise from zero after enable uses the same path
                if (s.eff < target)
                    next_s.eff = s.eff + 7'h01;
                else if (s.eff > target)
                    next_s.eff = s.eff - 7'h01;
            end
            else
                next_s.step_cnt = s.step_cnt + 16'h0001;
        end

        // half-cycle timebase from the zero-cross pulses
        if (line.zc)
        begin
            next_s.hc_count = '0;
            next_s.period = s.hc_count + 1'b1;
        end
        else if (~&s.hc_count)
            next_s.hc_count = s.hc_count + 1'b1;

        // plan for the half cycle that starts now
        if (line.zc)
        begin
            next_s.half_fire = 1'b0;
            next_s.num = 8'h00;
            next_s.den = 8'h01;
            sum = s.acc + {2'b00, s.eff};
            unique case (s.cfg.mode)
                tfp_pkg::TFP_PHASE, tfp_pkg::TFP_PHASE_SOFT:
                begin
                    next_s.half_fire = (s.eff != 7'h00);
                    next_s.num = {1'b0, tfp_pkg::TFP_PCT_FULL - s.eff};
                    next_s.den = {1'b0, tfp_pkg::TFP_PCT_FULL};
                end
                tfp_pkg::TFP_HALF:
                begin
                    if (s.eff == tfp_pkg::TFP_PCT_FULL)
                        next_s.half_fire = 1'b1;
                    else if (sum >= {2'b00, tfp_pkg::TFP_PCT_FULL} &&
                             line.line_pos != s.last_pol)
                    begin
                        next_s.half_fire = 1'b1;
                        next_s.acc = sum - {2'b00, tfp_pkg::TFP_PCT_FULL};
                        next_s.last_pol = line.line_pos;
                    end
                    else
                        // deferred credit is kept, saturating at TFP_ACC_CAP, so the average holds
                        next_s.acc = (sum > tfp_pkg::TFP_ACC_CAP) ?
                                     tfp_pkg::TFP_ACC_CAP : sum;
                end
                default:
                begin
                    if (cyc)
                    begin
                        if (s.blk_cnt == 8'h00)
                        begin
                            next_s.burst_on =
                                (s.eff == tfp_pkg::TFP_PCT_FULL) ||
                                (sum >= {2'b00, tfp_pkg::TFP_PCT_FULL});
                            next_s.acc = next_s.burst_on ?
                                sum - {2'b00, tfp_pkg::TFP_PCT_FULL} : sum;
                            next_s.blk_cnt = (s.cfg.min_cycles > 8'h01) ?
                                s.cfg.min_cycles - 8'h01 : 8'h00;
                            start = next_s.burst_on && !s.burst_on;
                        end
                        else
                            next_s.blk_cnt = s.blk_cnt - 8'h01;
                    end
                    if (start)
                        next_s.burst_half = 8'h00;
                    else if (~&s.burst_half)
                        next_s.burst_half = s.burst_half + 8'h01;
                    if (next_s.burst_on)
                    begin
                        next_s.half_fire = 1'b1;
                        if (s.cfg.mode == tfp_pkg::TFP_BURST_DELAY &&
                            next_s.burst_half <
                            s.cfg.delayed_half_cycle_count)
                        begin
                            next_s.num = s.cfg.delay_angle;
                            next_s.den = tfp_pkg::TFP_DEG_HALF;
                        end
                        else if (next_s.burst_half <
                                 s.cfg.ramp_half_cycles)
                        begin
                            next_s.num = s.cfg.ramp_half_cycles -
                                         next_s.burst_half - 8'h01;
                            next_s.den = s.cfg.ramp_half_cycles;
                        end
                    end
                end
            endcase
        end

        if (!run_enable)
        begin
            next_s.half_fire = 1'b0;
            next_s.burst_on = 1'b0;
            next_s.blk_cnt = 8'h00;
        end

        // fire once elapsed/period reaches num/den of the half cycle
        lhs = PRD_W'(next_s.hc_count) * PRD_W'(next_s.den);
        rhs = PRD_W'(next_s.num) * PRD_W'(next_s.period);
        next_s.gate = run_enable && next_s.half_fire &&
                      (next_s.num == 8'h00 ||
                       (next_s.period != '0 && lhs >= rhs));
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            s <= TFP_STATE_RST;
        else
            s <= next_s;
    end

    assign gate = s.gate;
    assign rdata = s.rdata;

    a_enable_off_stop: assert property (@(posedge mclk) disable iff (reset)
        !run_enable |=> !gate)
        else $error("gate active after enable dropped");

    a_full_demand_on: assert property (@(posedge mclk) disable iff (reset)
        (run_enable && s.eff == tfp_pkg::TFP_PCT_FULL && s.half_fire &&
         s.num == 8'h00)[*2] |-> gate)
        else $error("gate off at full demand");

    a_phase_bypass: assert property (@(posedge mclk) disable iff (reset)
        (run_enable && s.cfg.mode == tfp_pkg::TFP_PHASE)
        |=> s.eff == $past(s.cfg.set_point))
        else $error("plain phase demand not applied at once");

    a_soft_slew: assert property (@(posedge mclk) disable iff (reset)
        (run_enable && s.cfg.mode == tfp_pkg::TFP_PHASE_SOFT &&
         s.cfg.soft_time != 16'h0000)
        |=> (s.eff == $past(s.eff) || s.eff == $past(s.eff) + 7'h01 ||
             s.eff == $past(s.eff) - 7'h01))
        else $error("soft start demand jumped");

    a_enable_ramp: assert property (@(posedge mclk) disable iff (reset)
        ($rose(run_enable) && soft_act && s.cfg.soft_time != 16'h0000)
        |=> s.eff <= 7'h01)
        else $error("enable did not ramp from zero");

    a_half_alternate: assert property (@(posedge mclk) disable iff (reset)
        ($rose(s.half_fire) && s.cfg.mode == tfp_pkg::TFP_HALF &&
         s.eff != tfp_pkg::TFP_PCT_FULL && $past(run_enable))
        |-> s.last_pol != $past(s.last_pol))
        else $error("half-cycle firing not polarity balanced");

    a_burst_at_cycle: assert property (@(posedge mclk) disable iff (reset)
        ($rose(s.burst_on)) |-> $past(line.zc && line.line_pos))
        else $error("burst started off a cycle boundary");

    a_delay_angle: assert property (@(posedge mclk) disable iff (reset)
        ($rose(gate) && s.cfg.mode == tfp_pkg::TFP_BURST_DELAY &&
         s.burst_half < s.cfg.delayed_half_cycle_count)
        |-> PRD_W'(s.hc_count) * PRD_W'(tfp_pkg::TFP_DEG_HALF) >=
            PRD_W'(s.cfg.delay_angle) * PRD_W'(s.period))
        else $error("delayed burst fired before the delay angle");

    a_phase_trigger: assert property (@(posedge mclk) disable iff (reset)
        ($rose(gate) && s.cfg.mode == tfp_pkg::TFP_PHASE)
        |-> PRD_W'(s.hc_count) * PRD_W'(s.den) >=
            PRD_W'(s.num) * PRD_W'(s.period) &&
            s.den == {1'b0, tfp_pkg::TFP_PCT_FULL})
        else $error("phase gate fired before trigger angle");

endmodule

// File: core/tfp_pkg.sv
// shared constants and types for the thyristor firing pattern generator
package tfp_pkg;

    typedef enum logic [2:0] {
        TFP_BURST,
        TFP_BURST_DELAY,
        TFP_HALF,
        TFP_PHASE,
        TFP_PHASE_SOFT
    } tfp_mode_t;

    localparam int          TFP_ADDR_W    = 8;
    localparam int          TFP_DATA_W    = 16;
    localparam logic [2:0]  TFP_MODE_MAX  = 3'h4;

    // register offsets
    localparam logic [7:0]  TFP_REG_CTRL      = 8'h00;
    localparam logic [7:0]  TFP_REG_SETPOINT  = 8'h04;
    localparam logic [7:0]  TFP_REG_MIN_CYC   = 8'h08;
    localparam logic [7:0]  TFP_REG_DELAY     = 8'h0c;
    localparam logic [7:0]  TFP_REG_DELAY_HC  = 8'h10;
    localparam logic [7:0]  TFP_REG_SOFT_TIME = 8'h14;
    localparam logic [7:0]  TFP_REG_RAMP      = 8'h18;
    localparam logic [7:0]  TFP_REG_STATUS    = 8'h1c;

    // control field positions
    localparam int          TFP_CTRL_SOFT_BIT = 3;

    // scale and timing
    localparam logic [6:0]  TFP_PCT_FULL      = 7'h64;
    localparam logic [7:0]  TFP_DEG_HALF      = 8'hb4;
    localparam logic [8:0]  TFP_ACC_CAP       = 9'h0c7;
    localparam int          TFP_CLK_MHZ       = 200;
    localparam int          TFP_SOFT_STEP_MS  = 50;
    localparam int          TFP_SOFT_SUB_US   =
        TFP_SOFT_STEP_MS * 1000 / 100;
    localparam int          TFP_SOFT_SUB_CYC  = TFP_SOFT_SUB_US * TFP_CLK_MHZ;

    // reset values
    localparam logic [7:0]  TFP_MIN_CYC_RST   = 8'h01;
    localparam logic [7:0]  TFP_DELAY_RST     = 8'h50;
    localparam logic [7:0]  TFP_DELAY_HC_RST  = 8'h01;

    typedef struct packed {
        tfp_mode_t   mode;
        logic        soft_en;
        logic [6:0]  set_point;
        logic [7:0]  min_cycles;
        logic [7:0]  delay_angle;
        logic [7:0]  delayed_half_cycle_count;
        logic [15:0] soft_time;
        logic [7:0]  ramp_half_cycles;
    } tfp_cfg_t;

    localparam tfp_cfg_t TFP_CFG_RST = '{
        mode:                     TFP_BURST,
        soft_en:                  1'b0,
        set_point:                7'h00,
        min_cycles:               TFP_MIN_CYC_RST,
        delay_angle:              TFP_DELAY_RST,
        delayed_half_cycle_count: TFP_DELAY_HC_RST,
        soft_time:                16'h0000,
        ramp_half_cycles:         8'h00
    };

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } tfp_bus_t;

    typedef struct packed {
        logic zc;
        logic line_pos;
    } tfp_line_t;

endpackage

// File: testbench/tfp_line_model.sv
// line zero-cross source and gate observer for the firing pattern bench
`timescale 1ns/1ps
module tfp_line_model #(
    parameter int HALF = 100
) (
    input  wire logic          mclk,
    input  wire logic          clr,
    input  wire logic          gate,
    output tfp_pkg::tfp_line_t line,
    output logic [7:0]         rise_at,
    output logic [7:0]         on_pos,
    output logic [7:0]         on_neg,
    output logic [15:0]        low_cnt
);
    logic [7:0] hc;
    logic       seen;
    logic       gate_q;

    initial
    begin
        line = '0;
        hc = 8'h00;
        seen = 1'b0;
        gate_q = 1'b0;
    end

    // zero crossings alternate polarity, pos level leads in the zc cycle
    always @(posedge mclk)
    begin
        hc <= (hc == 8'(HALF - 1)) ? 8'h00 : hc + 8'h01;
        line.zc <= (hc == 8'(HALF - 1));
        if (hc == 8'(HALF - 1))
            line.line_pos <= ~line.line_pos;
        gate_q <= gate;
        if (gate && !gate_q)
            rise_at <= hc;
        // gate trails the zc by one cycle: the hc 0 sample is the old half
        seen <= (hc == 8'(HALF - 1)) ? 1'b0 :
                (seen | (gate && hc != 8'h00));
        if (clr)
        begin
            on_pos <= 8'h00;
            on_neg <= 8'h00;
            low_cnt <= 16'h0000;
        end
        else
        begin
            low_cnt <= low_cnt + 16'(!gate);
            if (hc == 8'(HALF - 1) && (seen || gate) && line.line_pos)
                on_pos <= on_pos + 8'h01;
            if (hc == 8'(HALF - 1) && (seen || gate) && !line.line_pos)
                on_neg <= on_neg + 8'h01;
        end
    end
endmodule

// File: testbench/thyristor_firing_pattern_gen_bench.sv
// self-checking bench for the thyristor firing pattern generator
`timescale 1ns/1ps
module thyristor_firing_pattern_gen_bench;
    localparam int HALF = 100;
    logic               mclk;
    logic               reset;
    tfp_pkg::tfp_bus_t  bus;
    logic [15:0]        rdata;
    tfp_pkg::tfp_line_t line;
    logic               run_enable;
    logic               gate;
    logic               clr;
    logic [7:0]         rise_at;
    logic [7:0]         on_pos;
    logic [7:0]         on_neg;
    logic [15:0]        low_cnt;
    logic [15:0]        rv;
    int                 failures;
    int                 tests_run;

    tfp_gen #(.CNT_W(22), .SOFT_SUB_CYC(10)) uut (
        .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
        .line(line), .run_enable(run_enable), .gate(gate));
    tfp_line_model #(.HALF(HALF)) line_src (
        .mclk(mclk), .clr(clr), .gate(gate), .line(line),
        .rise_at(rise_at), .on_pos(on_pos), .on_neg(on_neg),
        .low_cnt(low_cnt));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // lo..hi window for values that depend on line alignment
    task automatic range(string name, int lo, int hi, logic [15:0] got);
        check(name, 16'h0001, 16'((got >= lo) && (got <= hi)));
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask

    // aligned to a zc so that the window holds exactly n whole halves
    task automatic halves(int n, logic clear);
        do
            @(posedge mclk);
        while (!line.zc);
        clr <= clear;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n * HALF) @(posedge mclk);
    endtask

    task automatic t_reset_vals();
        rd(tfp_pkg::TFP_REG_CTRL);
        check("ctrl", 16'h0000, rv);
        rd(tfp_pkg::TFP_REG_MIN_CYC);
        check("min_cyc", 16'h0001, rv);
        rd(tfp_pkg::TFP_REG_DELAY);
        check("delay", 16'h0050, rv);
        rd(tfp_pkg::TFP_REG_DELAY_HC);
        check("delay_hc", 16'h0001, rv);
        rd(8'h20);
        check("unmapped", 16'h0000, rv);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0078);
        rd(tfp_pkg::TFP_REG_SETPOINT);
        check("clamp", 16'h0064, rv);
    endtask

    task automatic t_phase();
        int d;
        wr(tfp_pkg::TFP_REG_CTRL, 16'h0003);
        for (int i = 1; i <= 3; i++)
        begin
            d = 25 * i;
            wr(tfp_pkg::TFP_REG_SETPOINT, 16'(d));
            halves(4, 1'b1);
            range("trigger", HALF * (100 - d) / 100,
                  HALF * (100 - d) / 100 + 4, rise_at);
            check("phase_bal", 16'(on_pos), 16'(on_neg));
            range("on_halves", 4, 4, on_pos + on_neg);
        end
    endtask

    task automatic t_full();
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0064);
        for (int m = 0; m <= 4; m++)
        begin
            wr(tfp_pkg::TFP_REG_CTRL, 16'(m));
            halves(6, 1'b0);
            halves(4, 1'b1);
            range("full_low", 0, 2, low_cnt);
        end
    endtask

    task automatic t_half();
        wr(tfp_pkg::TFP_REG_CTRL, 16'h0002);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0032);
        halves(20, 1'b1);
        range("half_50", 9, 11, on_pos + on_neg);
        range("half_bal", 0, 1, on_pos - on_neg);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0019);
        halves(24, 1'b1);
        range("half_25", 5, 7, on_pos + on_neg);
        range("half_bal25", 0, 1, on_pos - on_neg + 1);
    endtask

    task automatic t_burst_delay();
        wr(tfp_pkg::TFP_REG_MIN_CYC, 16'h0002);
        wr(tfp_pkg::TFP_REG_DELAY, 16'h0032);
        wr(tfp_pkg::TFP_REG_CTRL, 16'h0001);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0032);
        halves(32, 1'b1);
        range("burst_50", 14, 18, on_pos + on_neg);
        range("delay_rise", HALF * 50 / 180, HALF * 50 / 180 + 4,
              rise_at);
        wr(tfp_pkg::TFP_REG_DELAY, 16'h0050);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h0019);
        halves(64, 1'b1);
        range("burst_25", 14, 18, on_pos + on_neg);
        range("delay80_rise", HALF * 80 / 180, HALF * 80 / 180 + 4,
              rise_at);
        wr(tfp_pkg::TFP_REG_CTRL, 16'h0000);
        wr(tfp_pkg::TFP_REG_RAMP, 16'h0002);
        halves(24, 1'b1);
        range("ramp_rise", HALF / 2, HALF / 2 + 4, rise_at);
        wr(tfp_pkg::TFP_REG_RAMP, 16'h0000);
    endtask

    task automatic t_soft();
        wr(tfp_pkg::TFP_REG_SOFT_TIME, 16'h0001);
        wr(tfp_pkg::TFP_REG_CTRL, 16'h0004);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h003c);
        run_enable <= 1'b0;
        halves(1, 1'b0);
        run_enable <= 1'b1;
        rd(tfp_pkg::TFP_REG_STATUS);
        range("soft_start", 0, 2, {9'h000, rv[6:0]});
        repeat (300) @(posedge mclk);
        rd(tfp_pkg::TFP_REG_STATUS);
        range("soft_mid", 20, 40, {9'h000, rv[6:0]});
        rd(tfp_pkg::TFP_REG_STATUS);
        range("soft_mid", 20, 40, {9'h000, rv[6:0]});
        repeat (500) @(posedge mclk);
        rd(tfp_pkg::TFP_REG_STATUS);
        check("soft_end", 16'h003c, {9'h000, rv[6:0]});
        @(posedge mclk);
        run_enable <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 check("stop_gate", 16'h0000, 16'(gate));
        rd(tfp_pkg::TFP_REG_STATUS);
        check("stop_eff", 16'h0000, rv);
        @(posedge mclk);
        run_enable <= 1'b1;
        wr(tfp_pkg::TFP_REG_CTRL, 16'h000b);
        wr(tfp_pkg::TFP_REG_SETPOINT, 16'h001e);
        rd(tfp_pkg::TFP_REG_STATUS);
        check("plain_eff", 16'h001e, {9'h000, rv[6:0]});
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #(5 * 60000);
        failures++;
        final_report();
    end

    initial
    begin
        failures = 0;
        tests_run = 0;
        reset = 1'b1;
        bus = '0;
        run_enable = 1'b0;
        clr = 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_reset_vals();
        @(posedge mclk);
        run_enable <= 1'b1;
        halves(3, 1'b1);
        t_phase();
        t_full();
        t_half();
        t_burst_delay();
        t_soft();
        final_report();
    end
endmodule
